// [evpsc_pkg.sv]
// constants and types shared by the pilot pwm and state control block
//
// Behaviour
// - pilot is a 1 kHz +/-12 V pwm
// - 6..51 A: duty percent equals amps/0.6
// - 51..80 A: duty percent is amps/2.5+64
// - rated current is a fixed build constant
// - software may derate the advertised current
// - after self test, enter not-connected, steady +12 V
// - not-connected state keeps pilot at steady 12 V
// - 9 V: connect, start pwm, close relays
// - 6 V means charging, pwm and relays on
// - 3 V with -12 V low: charging, ventilated
// - back to 12 V: open relays, not-connected
// - pilot faults cut power to the vehicle
// - relays held only while actively driven
// - verify contacts opened after every relay opening
// - mains sense input is high when voltage present
package evpsc_pkg;

    localparam int CLK_HZ      = 50_000_000;
    localparam int PWM_HZ      = 1000;
    localparam int PERIOD_CYC  = CLK_HZ / PWM_HZ;
    localparam int WELD_WAIT_MS  = 100;
    localparam int WELD_WAIT_CYC = WELD_WAIT_MS * (CLK_HZ / 1000);
    localparam int SETTLE_US   = 20;
    localparam int SETTLE_CYC  = SETTLE_US * (CLK_HZ / 1_000_000);

    // duty mapping, amps
    localparam logic [6:0] AMPS_MIN   = 7'd6;
    localparam logic [6:0] AMPS_SPLIT = 7'd51;
    localparam logic [6:0] AMPS_MAX   = 7'd80;
    localparam logic [6:0] RATED_AMPS = 7'd32;

    // pilot samples are signed, units of 10 mV
    localparam logic signed [15:0] THR_12_9 = 16'sd1050;
    localparam logic signed [15:0] THR_9_6  = 16'sd750;
    localparam logic signed [15:0] THR_6_3  = 16'sd450;
    localparam logic signed [15:0] THR_3_0  = 16'sd150;
    localparam logic signed [15:0] THR_0_N  = -16'sd150;
    localparam logic signed [15:0] LOW_MAX  = -16'sd1050;

    localparam logic [1:0] DEB_PERIODS = 2'd3;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_DERATE = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_AMPS   = 8'h0c;
    localparam logic [7:0] OFS_PILOT  = 8'h10;

    localparam int CTRL_ENABLE  = 0;
    localparam int CTRL_DERATE  = 1;
    localparam int STAT_WELD    = 9;
    localparam int STAT_PFAULT  = 10;
    localparam logic [6:0] DERATE_RST = 7'd32;

    typedef enum logic [2:0] {
        ST_SELFTEST,
        ST_IDLE,
        ST_CONN,
        ST_CHG,
        ST_VENT,
        ST_WELD,
        ST_FAULT
    } evpsc_state_t;

    typedef enum logic [2:0] {
        CLS_12V,
        CLS_9V,
        CLS_6V,
        CLS_3V,
        CLS_0V,
        CLS_NEG,
        CLS_NODIODE
    } evpsc_cls_t;

endpackage : evpsc_pkg

// [evpsc_sync.sv]
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
`default_nettype none
module evpsc_sync (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic asyncIn,
    output logic      syncOut
);
    typedef struct packed {
        logic s1;
        logic s2;
    } evpsc_sync_t;

    evpsc_sync_t r;
    evpsc_sync_t next_r;

    // s1 feeds only s2
    always_comb begin
        next_r.s1 = asyncIn;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign syncOut = r.s2;
endmodule : evpsc_sync
`default_nettype wire

// [evpsc_pilot_ctrl.sv]
// pilot pwm generator, pilot state machine and relay sequencing
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module evpsc_pilot_ctrl
    import evpsc_pkg::*;
#(
    parameter int PERIOD_CYCLES = PERIOD_CYC,
    parameter int WELD_CYCLES   = WELD_WAIT_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        adcValid,
    input  wire logic [15:0] adcData,
    input  wire logic        mainsSense,
    output logic             pilotDrive,
    output logic             relayOn,
    output logic             faultFlag
);
    typedef struct packed {
        evpsc_state_t     st;
        logic             goFault;
        logic [15:0]      cnt;
        logic [15:0]      dutyOn;
        logic [15:0]      edgeAge;
        logic             pilotDrive;
        logic             relayOn;
        logic signed [15:0] hiSmp;
        logic signed [15:0] loSmp;
        logic             hiSeen;
        logic             loSeen;
        evpsc_cls_t       cls;
        evpsc_cls_t       cand;
        logic [1:0]       deb;
        logic [23:0]      weldCnt;
        logic             weldFault;
        logic             pilotFault;
        logic             clamped;
        logic [6:0]       effAmps;
        logic             enable;
        logic             derateEn;
        logic [6:0]       derate;
        logic             ack;
        logic [31:0]      dat;
    } evpsc_regs_t;

    // the whole state of the block, registered in one step
    evpsc_regs_t r;
    evpsc_regs_t next_r;
    logic        mainsSync;

    // mains presence comes from an optocoupler, asynchronous
    evpsc_sync u_mains_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .asyncIn  (mainsSense),
        .syncOut  (mainsSync)
    );

    // nearest nominal level, midpoint thresholds down to 0 V; below -1.5 V counts as negative
    function automatic evpsc_cls_t classify(input logic signed [15:0] v);
        if (v >= THR_12_9) begin
            classify = CLS_12V;
        end else if (v >= THR_9_6) begin
            classify = CLS_9V;
        end else if (v >= THR_6_3) begin
            classify = CLS_6V;
        end else if (v >= THR_3_0) begin
            classify = CLS_3V;
        end else if (v >= THR_0_N) begin
            classify = CLS_0V;
        end else begin
            classify = CLS_NEG;
        end
    endfunction : classify

    // on-time in clock cycles for a current in whole amps
    // division truncates: on-time may run one cycle short
    function automatic logic [15:0] onCycles(input logic [6:0] a);
        logic [31:0] p;
        p = 32'(PERIOD_CYCLES);
        if (a <= AMPS_SPLIT) begin
            onCycles = 16'(p * 32'(a) / 32'd60);
        end else begin
            onCycles = 16'(p * (32'(a) * 32'd4 + 32'd640) / 32'd1000);
        end
    endfunction : onCycles

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    function automatic logic isFaultCls(input evpsc_cls_t c);
        isFaultCls = (c == CLS_0V) || (c == CLS_NEG) || (c == CLS_NODIODE);
    endfunction : isFaultCls

    function automatic logic isDriving(input evpsc_state_t s);
        isDriving = (s == ST_CONN) || (s == ST_CHG) || (s == ST_VENT);
    endfunction : isDriving

    logic       access;
    logic       periodEnd;
    logic       pwmOn;
    logic [6:0] baseAmps;
    logic [6:0] clampAmps;
    logic       outOfRange;
    evpsc_cls_t newCls;

    always_comb begin
        next_r     = r;
        access     = cyc_i & stb_i & ~r.ack;
        periodEnd  = (r.cnt == 16'(PERIOD_CYCLES - 1));
        pwmOn      = isDriving(r.st);
        baseAmps   = RATED_AMPS;
        clampAmps  = RATED_AMPS;
        outOfRange = 1'b0;
        newCls     = classify(r.hiSmp);

        // classic wishbone: one wait state, ack drops after one cycle
        // a request still up while ack shows is not taken twice
        next_r.ack = access;
        if (access && !we_i) begin
            // unmapped addresses read back as zero
            next_r.dat = '0;
            if (hit(adr_i, OFS_CTRL)) begin
                next_r.dat[CTRL_ENABLE] = r.enable;
                next_r.dat[CTRL_DERATE] = r.derateEn;
            end else if (hit(adr_i, OFS_DERATE)) begin
                next_r.dat[6:0] = r.derate;
            end else if (hit(adr_i, OFS_STATUS)) begin
                next_r.dat[2:0]  = r.st;
                next_r.dat[5:3]  = r.cls;
                next_r.dat[8]    = r.relayOn;
                next_r.dat[STAT_WELD]   = r.weldFault;
                next_r.dat[STAT_PFAULT] = r.pilotFault;
                next_r.dat[11]   = (r.st == ST_VENT);
                next_r.dat[12]   = r.clamped;
                next_r.dat[13]   = mainsSync;
            end else if (hit(adr_i, OFS_AMPS)) begin
                next_r.dat[6:0]   = r.effAmps;
                next_r.dat[31:16] = r.dutyOn;
            end else if (hit(adr_i, OFS_PILOT)) begin
                next_r.dat[15:0]  = r.hiSmp;
                next_r.dat[31:16] = r.loSmp;
            end
        end
        if (access && we_i) begin
            if (hit(adr_i, OFS_CTRL) && sel_i[0]) begin
                next_r.enable   = dat_i[CTRL_ENABLE];
                next_r.derateEn = dat_i[CTRL_DERATE];
            end
            if (hit(adr_i, OFS_DERATE) && sel_i[0]) begin
                next_r.derate = dat_i[6:0];
            end
            // write one to clear; hardware sets below win
            if (hit(adr_i, OFS_STATUS) && sel_i[1]) begin
                if (dat_i[STAT_WELD]) begin
                    next_r.weldFault = 1'b0;
                end
                if (dat_i[STAT_PFAULT]) begin
                    next_r.pilotFault = 1'b0;
                end
            end
        end

        // advertised current, derated and clamped
        // derating only lowers the current, never above the rating
        if (r.derateEn && r.derate < RATED_AMPS) begin
            baseAmps = r.derate;
        end
        if (baseAmps < AMPS_MIN) begin
            clampAmps  = AMPS_MIN;
            outOfRange = 1'b1;
        end else if (baseAmps > AMPS_MAX) begin
            clampAmps  = AMPS_MAX;
            outOfRange = 1'b1;
        end else begin
            clampAmps = baseAmps;
        end

        // free-running 1 kHz period; duty only changes on a boundary
        if (periodEnd) begin
            next_r.cnt     = '0;
            next_r.effAmps = clampAmps;
            next_r.clamped = outOfRange;
            next_r.dutyOn  = onCycles(clampAmps);
        end else begin
            next_r.cnt = r.cnt + 16'd1;
        end

        // skip samples taken while the amplifier is still slewing
        // limitation: a level shorter than the settle time is never sampled
        if (adcValid && r.edgeAge >= 16'(SETTLE_CYC)) begin
            if (r.pilotDrive) begin
                next_r.hiSmp  = adcData;
                next_r.hiSeen = 1'b1;
            end else begin
                next_r.loSmp  = adcData;
                next_r.loSeen = 1'b1;
            end
        end

        // missing diode: negative swing not reaching -12 V
        if (pwmOn && r.loSeen && r.loSmp > LOW_MAX) begin
            newCls = CLS_NODIODE;
        end
        if (periodEnd) begin
            next_r.hiSeen = 1'b0;
            next_r.loSeen = 1'b0;
            // class moves after DEB_PERIODS matching periods in a row, or at once to CLS_NEG below
            if (r.hiSeen || newCls == CLS_NODIODE) begin
                if (newCls != r.cand) begin
                    next_r.cand = newCls;
                    next_r.deb  = 2'd1;
                end else if (r.deb != DEB_PERIODS) begin
                    next_r.deb = r.deb + 2'd1;
                end
                if (newCls == r.cand && r.deb >= DEB_PERIODS - 2'd1) begin
                    next_r.cls = newCls;
                end
            end else begin
                // no positive level seen at all in a driven period
                if (pwmOn) begin
                    next_r.cls = CLS_NEG;
                end
            end
        end

        // counter runs only in the weld check and restarts on each entry
        next_r.weldCnt = '0;
        case (r.st)
            ST_SELFTEST: begin
                // software sets enable once its self tests pass
                if (r.enable) begin
                    next_r.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (!r.enable) begin
                    next_r.st = ST_SELFTEST;
                end else if (r.cls == CLS_9V && !r.weldFault) begin
                    next_r.st = ST_CONN;
                end else if (isFaultCls(r.cls)) begin
                    next_r.st = ST_FAULT;
                    next_r.pilotFault = 1'b1;
                end
            end
            ST_CONN, ST_CHG, ST_VENT: begin
                // every opening goes through the weld check first
                if (!r.enable || r.cls == CLS_12V) begin
                    next_r.st      = ST_WELD;
                    next_r.goFault = 1'b0;
                end else if (isFaultCls(r.cls)) begin
                    next_r.st         = ST_WELD;
                    next_r.goFault    = 1'b1;
                    next_r.pilotFault = 1'b1;
                end else if (r.cls == CLS_6V) begin
                    next_r.st = ST_CHG;
                end else if (r.cls == CLS_3V) begin
                    next_r.st = ST_VENT;
                end else begin
                    next_r.st = ST_CONN;
                end
            end
            ST_WELD: begin
                // wait for the contacts to drop, then look at the output
                // goFault remembers why the relays were opened
                if (r.weldCnt >= 24'(WELD_CYCLES - 1)) begin
                    if (mainsSync) begin
                        next_r.weldFault = 1'b1;
                        next_r.st        = ST_FAULT;
                    end else if (r.goFault) begin
                        next_r.st = ST_FAULT;
                    end else begin
                        next_r.st = ST_IDLE;
                    end
                end else begin
                    next_r.weldCnt = r.weldCnt + 24'd1;
                end
            end
            ST_FAULT: begin
                // stays until unplugged and any weld flag is cleared
                if (r.cls == CLS_12V && !r.weldFault) begin
                    next_r.st = ST_IDLE;
                end
            end
            default: begin
                next_r.st = ST_SELFTEST;
            end
        endcase

        // relay held only in the driving states, dropped otherwise
        // no latch: losing the drive state opens the relays at once
        next_r.relayOn = isDriving(next_r.st);

        case (next_r.st)
            ST_CONN, ST_CHG, ST_VENT: begin
                next_r.pilotDrive = (next_r.cnt < next_r.dutyOn);
            end
            ST_IDLE, ST_WELD, ST_FAULT: begin
                // steady +12 V lets the vehicle see plug-in and unplug
                next_r.pilotDrive = 1'b1;
            end
            default: begin
                // self test parks the pilot at -12 V
                next_r.pilotDrive = 1'b0;
            end
        endcase

        // saturates so a long steady level never wraps under the settle time
        if (next_r.pilotDrive != r.pilotDrive) begin
            next_r.edgeAge = '0;
        end else if (r.edgeAge != 16'hffff) begin
            next_r.edgeAge = r.edgeAge + 16'd1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            // derate and amps start at the rating, not at zero
            r         <= '0;
            r.derate  <= DERATE_RST;
            r.effAmps <= RATED_AMPS;
        end else begin
            r <= next_r;
        end
    end

    assign dat_o      = r.dat;
    assign ack_o      = r.ack;
    assign pilotDrive = r.pilotDrive;
    assign relayOn    = r.relayOn;
    assign faultFlag  = r.weldFault | r.pilotFault;
endmodule : evpsc_pilot_ctrl
`default_nettype wire

// [evpsc_vehicle_model.sv]
// vehicle model: load levels on the pilot sense path and mains sense
`timescale 1ns/10ps
`default_nettype none
module evpsc_vehicle_model (
    input  wire logic               core_clk,
    input  wire logic               resetn,
    input  wire logic               pilotDrive,
    input  wire logic               relayOn,
    input  wire logic signed [15:0] hiLevel,
    input  wire logic               welded,
    output logic                    adcValid,
    output logic             [15:0] adcData,
    output logic                    mainsSense
);
    logic        [3:0]  cnt;
    logic signed [15:0] v;
    // the vehicle load sets the high level; state e has no negative swing
    assign v = pilotDrive ? hiLevel
             : (hiLevel == 16'sh0 ? 16'sh0 : -16'sd1200);
    // stuck contacts keep mains present after the drive is removed
    assign mainsSense = relayOn | welded;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt      <= 4'h0;
            adcValid <= 1'b0;
            adcData  <= 16'h0;
        end else begin
            cnt      <= cnt + 4'h1;
            adcValid <= (cnt == 4'h0);
            // between strobes the data bus shows junk, never the sample
            adcData  <= (cnt == 4'h0) ? v : ~v;
        end
    end
endmodule : evpsc_vehicle_model
`default_nettype wire

// [evpsc_pilot_ctrl_assertions.sv]
// port-level assertions for the pilot controller
`timescale 1ns/10ps
`default_nettype none
module evpsc_pilot_ctrl_chk #(
    parameter int PERIOD_CYCLES = 50000,
    parameter int WELD_CYCLES   = 5000000
) (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        adcValid,
    input wire logic [15:0] adcData,
    input wire logic        mainsSense,
    input wire logic        pilotDrive,
    input wire logic        relayOn,
    input wire logic        faultFlag
);
    // margin covers the two-stage sync and state hand-off
    localparam logic [31:0] WLIM = WELD_CYCLES + 10;
    logic [31:0] stillCnt, riseCnt, weldCnt;
    logic        pPrev, rPrev, seenRise, armed;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stillCnt <= '0;
            riseCnt  <= '0;
            weldCnt  <= '0;
            pPrev    <= 1'b0;
            rPrev    <= 1'b0;
            seenRise <= 1'b0;
            armed    <= 1'b0;
        end else begin
            pPrev    <= pilotDrive;
            rPrev    <= relayOn;
            stillCnt <= (pilotDrive != pPrev || !relayOn) ? '0 : stillCnt + 1;
            riseCnt  <= (pilotDrive && !pPrev) ? 32'h1 : riseCnt + 1;
            seenRise <= relayOn && (seenRise || (pilotDrive && !pPrev));
            armed    <= !relayOn && mainsSense && (armed || rPrev);
            weldCnt  <= !armed ? '0 : (weldCnt == WLIM ? WLIM : weldCnt + 1);
        end
    end
    chk_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_unmapped_read: assert property (cyc_i && stb_i && !ack_o && !we_i
        && adr_i > 8'h10 |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_pwm_running: assert property (
        relayOn |-> stillCnt < PERIOD_CYCLES)
        else $error("pilot not modulated while relays closed");
    chk_pwm_period: assert property (
        $rose(pilotDrive) && relayOn && seenRise
        |-> riseCnt == PERIOD_CYCLES)
        else $error("pilot period wrong");
    chk_steady_idle: assert property ($fell(pilotDrive) |-> relayOn)
        else $error("pilot left steady level without relays");
    chk_fault_open: assert property (
        faultFlag [*3] |-> !relayOn)
        else $error("relays closed during fault");
    chk_weld_flag: assert property (
        weldCnt == WLIM |-> faultFlag)
        else $error("welded contacts not flagged");
endmodule : evpsc_pilot_ctrl_chk
bind evpsc_pilot_ctrl evpsc_pilot_ctrl_chk #(
    .PERIOD_CYCLES(PERIOD_CYCLES), .WELD_CYCLES(WELD_CYCLES)) u_chk (
    .core_clk(core_clk), .resetn(resetn), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .adcValid(adcValid), .adcData(adcData),
    .mainsSense(mainsSense), .pilotDrive(pilotDrive), .relayOn(relayOn),
    .faultFlag(faultFlag));
`default_nettype wire

// [ev_pilot_pwm_state_control_tb.sv]
// testbench for the pilot pwm and state control block
`timescale 1ns/10ps
`default_nettype none
module ev_pilot_pwm_state_control_tb import evpsc_pkg::*;;
    localparam int PER = 2200;
    logic               core_clk = 0, resetn = 0, cyc = 0, stb = 0;
    logic               we = 0, welded = 0;
    logic        [7:0]  adr = '0;
    logic        [3:0]  sel = '0;
    logic        [31:0] wdat = '0, dat_o, q;
    logic               ack_o, adcValid, mainsSense, pilotDrive;
    logic               relayOn, faultFlag;
    logic        [15:0] adcData;
    logic signed [15:0] hiLevel = 16'sd1200;
    int                 errors = 0, num_checks = 0, h;
    evpsc_pilot_ctrl #(.PERIOD_CYCLES(PER), .WELD_CYCLES(20)) DUT (
        .core_clk(core_clk), .resetn(resetn), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o),
        .ack_o(ack_o), .adcValid(adcValid), .adcData(adcData),
        .mainsSense(mainsSense), .pilotDrive(pilotDrive),
        .relayOn(relayOn), .faultFlag(faultFlag));
    evpsc_vehicle_model ev (.core_clk(core_clk), .resetn(resetn),
        .pilotDrive(pilotDrive), .relayOn(relayOn), .hiLevel(hiLevel),
        .welded(welded), .adcValid(adcValid), .adcData(adcData),
        .mainsSense(mainsSense));
    always #10 core_clk = ~core_clk;
    task finish_test;
        if (errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s);
        int n;
        @(posedge core_clk);
        {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, s};
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            finish_test();
        end
        q = dat_o;
        {cyc, stb, we} <= 3'b000;
    endtask : wb
    task waitst(input logic [2:0] s);
        int n;
        n = 0;
        do begin
            wb(1'b0, OFS_STATUS, 32'h0, 4'hf);
            n++;
        end while (q[2:0] !== s && n < 8000);
        chk(q[2:0], s);
        if (q[2:0] !== s) finish_test();
    endtask : waitst
    // h counts the cycles spent before the pilot reaches level v
    task waitLvl(input logic v);
        h = 0;
        while (pilotDrive !== v && h < 9000) begin
            @(posedge core_clk);
            h++;
        end
        if (h >= 9000) begin
            errors++;
            finish_test();
        end
    endtask : waitLvl
    initial begin
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        chk({pilotDrive, relayOn, faultFlag}, 3'b000);
        wb(1'b0, 8'h20, 32'h0, 4'hf);
        chk(q, 32'h0);
        waitst(3'd0);
        wb(1'b1, OFS_CTRL, 32'h1, 4'h1);
        waitst(3'd1);
        h = 0;
        repeat (2 * PER) begin
            @(posedge core_clk);
            h += (pilotDrive !== 1'b1);
        end
        chk(h, 0);
        // derate below the legal floor must clamp to the minimum
        wb(1'b1, OFS_DERATE, 32'h3, 4'h1);
        wb(1'b1, OFS_CTRL, 32'h3, 4'h1);
        // duty and amps only move on a period boundary
        repeat (PER) @(posedge core_clk);
        wb(1'b0, OFS_AMPS, 32'h0, 4'hf);
        chk({q[31:16], q[6:0]}, {16'(PER * 6 / 60), 7'd6});
        wb(1'b0, OFS_STATUS, 32'h0, 4'hf);
        chk(q[12], 1'b1);
        wb(1'b1, OFS_CTRL, 32'h1, 4'h1);
        repeat (PER) @(posedge core_clk);
        wb(1'b0, OFS_AMPS, 32'h0, 4'hf);
        chk(q[31:16], PER * 32 / 60);
        hiLevel <= 16'sd900;
        waitst(3'd2);
        chk(relayOn, 1'b1);
        waitLvl(1'b0);
        waitLvl(1'b1);
        waitLvl(1'b0);
        chk(h, PER * 32 / 60);
        hiLevel <= 16'sd600;
        waitst(3'd3);
        chk(relayOn, 1'b1);
        hiLevel <= 16'sd300;
        waitst(3'd4);
        chk({q[11], relayOn}, 2'b11);
        hiLevel <= 16'sd1200;
        waitst(3'd1);
        chk({relayOn, faultFlag}, 2'b00);
        hiLevel <= 16'sd900;
        waitst(3'd2);
        welded <= 1'b1;
        hiLevel <= 16'sd1200;
        waitst(3'd6);
        wb(1'b0, OFS_STATUS, 32'h0, 4'hf);
        chk({q[9], faultFlag}, 2'b11);
        hiLevel <= 16'sd900;
        repeat (4 * PER) @(posedge core_clk);
        chk(relayOn, 1'b0);
        // fault is left only when unplugged and the weld flag is cleared
        welded <= 1'b0;
        hiLevel <= 16'sd1200;
        wb(1'b1, OFS_STATUS, 32'h200, 4'h2);
        wb(1'b0, OFS_STATUS, 32'h0, 4'hf);
        chk(q[9], 1'b0);
        waitst(3'd1);
        hiLevel <= 16'sd900;
        waitst(3'd2);
        hiLevel <= 16'sh0;
        waitst(3'd6);
        chk({relayOn, faultFlag}, 2'b01);
        finish_test();
    end
endmodule : ev_pilot_pwm_state_control_tb
`default_nettype wire
